// ### shared/mtr_map.vh
// register map and field layout of the multiphase timing router
// assumes byte-wide registers reached over a byte-addressed register port
`ifndef MTR_MAP_VH
`define MTR_MAP_VH

// register offsets
`define MTR_GATE_DRIVE_ENABLE      8'h01
`define MTR_LOOP1_CLOCK_DIVIDER    8'h09
`define MTR_LOOP2_CLOCK_DIVIDER    8'h0a
`define MTR_LOOP1_PHASE_ENABLE     8'h0b
`define MTR_LOOP2_PHASE_ENABLE     8'h0c
`define MTR_LOOP1_OFFTIME_DELAY    8'h0d
`define MTR_LOOP2_OFFTIME_DELAY    8'h0e
`define MTR_PHASE_LOOP_ASSOCIATION 8'h0f
`define MTR_DRIVER_ROUTING_SELECT  8'h10
`define MTR_DRIVE_STATUS           8'h1f

// field positions inside the off-time/delay registers
`define MTR_STEP_DELAY_MSB 7
`define MTR_STEP_DELAY_LSB 3
`define MTR_OFF_TIME_MSB   2
`define MTR_OFF_TIME_LSB   0

// reset values
`define MTR_RST_BYTE   8'h00
`define MTR_RST_NIBBLE 4'h0
`endif

// ### core/mtr_loop.v
// one regulation loop: oscillator divider and internal phase sequencer
// assumes settings are static while run is high (locked by the caller)
`timescale 1ns/1ps
module mtr_loop #(
    parameter DIV_W = 8,
    parameter NPH   = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             srst,
    // control
    input  wire             run,
    input  wire [DIV_W-1:0] divisor,
    input  wire [4:0]       step_delay,
    input  wire [2:0]       off_time,
    input  wire [NPH-1:0]   phase_en,
    // internal phases
    output wire [NPH-1:0]   phase_out
);
    reg  [DIV_W-1:0] div_cnt;
    reg  [4:0]       step_cnt;
    reg  [1:0]       cur;
    reg              go;
    reg  [2:0]       n_en;
    reg  [8:0]       period;
    wire [2:0]       off_len;
    wire [8:0]       on_len;
    wire             tick;
    wire             fire;
    wire [1:0]       fire_idx;
    integer          j;

    // next enabled phase above c, wrapping to the lowest
    function [1:0] next_en;
        input [1:0] c;
        input [3:0] e;
        integer   k;
        reg [2:0] t;
        reg [1:0] r;
        reg       f;
        begin
            r = c;
            f = 1'b0;
            for (k = 1; k <= 4; k = k + 1) begin
                t = {1'b0, c} + k[2:0];
                if (!f && e[t[1:0]]) begin
                    r = t[1:0];
                    f = 1'b1;
                end
            end
            next_en = r;
        end
    endfunction

    // divided clock as a one-cycle enable, divisor+1 oscillator cycles apart
    assign tick = run && (div_cnt == divisor); // RL5 RL6
    always @(posedge clk) begin
        if (srst || !run) begin
            div_cnt <= {DIV_W{1'b0}};
        end else if (tick) begin
            div_cnt <= {DIV_W{1'b0}};
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // switching period = enabled phases times step delay, in divided periods
    always @* begin
        n_en = 3'h0;
        for (j = 0; j < NPH; j = j + 1) begin
            n_en = n_en + {2'b00, phase_en[j]};
        end
        period = n_en * ({1'b0, step_delay} + 6'h01); // RL12 RL16
    end

    assign off_len = (off_time == 3'h0) ? 3'h1 : off_time; // RL10
    assign on_len  = (period > {6'h00, off_len}) ? (period - {6'h00, off_len}) : 9'h000; // RL7

    // a phase starts on the first tick and after each step delay
    assign fire     = tick && (|phase_en) && (!go || step_cnt == step_delay); // RL8 RL9
    assign fire_idx = next_en(go ? cur : 2'h3, phase_en); // RL17

    always @(posedge clk) begin
        if (srst || !run) begin
            step_cnt <= 5'h00;
            cur      <= 2'h0;
            go       <= 1'b0;
        end else if (fire) begin
            step_cnt <= 5'h00;
            cur      <= fire_idx;
            go       <= 1'b1;
        end else if (tick && go) begin
            step_cnt <= step_cnt + 5'h01;
        end
    end

    // per phase: age in divided periods since its last start
    genvar i;
    generate
        for (i = 0; i < NPH; i = i + 1) begin : g_ph
            reg [7:0] age;
            reg       seen;
            always @(posedge clk) begin
                if (srst || !run) begin
                    age  <= 8'h00;
                    seen <= 1'b0;
                end else if (fire && fire_idx == i) begin
                    age  <= 8'h00;
                    seen <= 1'b1;
                end else if (tick && age != 8'hff) begin
                    age <= age + 8'h01;
                end
            end
            // on from its start until off_len periods before its next start
            assign phase_out[i] = seen && phase_en[i] && ({1'b0, age} < on_len); // RL7 RL12
        end
    endgenerate
endmodule

// ### core/mtr_top.v
// multiphase timing router: register file, two loops, driver routing
// assumes a register port on clk driven by the serial front end, and a
// config_finished level from the mode logic on the same clock
`timescale 1ns/1ps
`include "mtr_map.vh"

// Functional notes
// RL1 - association bit 0 ties physical phase to loop 1, bit 1 to loop 2
// RL2 - software writes zero to upper four reserved bits of those registers
// RL3 - two-bit select per driver picks internal phase 1..4
// RL4 - physical phase switches only while its enable bit is 1
// RL5 - all phase timing comes from one common oscillator
// RL6 - each loop divides oscillator by eight-bit field plus one
// RL7 - divided clock times each phase's off interval
// RL8 - divided clock times delay between consecutive internal phases
// RL9 - phase delay is field plus one divided periods, 1 to 32
// RL10 - off time equals field in divided periods, zero gives one
// RL11 - loop 2 has its own delay and off-time register, same coding
// RL12 - phase restarts after loop steps through all its phases
// RL13 - software should set inter-phase delay near thirty-two periods
// RL14 - software must associate every used physical phase with a loop
// RL15 - configuration writes ignored once configuration is finished
// RL16 - per-loop enable registers set how many internal phases run
// RL17 - enabled internal phases fire ascending, wrapping to the lowest
// RL18 - disabled driver or not operating holds its output low
module mtr_top (
    // clock and reset
    input  wire       clk,
    input  wire       srst,
    // mode
    input  wire       config_finished,
    // register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr_en,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd_en,
    output reg  [7:0] reg_rdata,
    // gate drivers
    output reg  [3:0] gate_drive
);
    reg  [3:0] gate_drive_enable;
    reg  [7:0] loop1_clock_divider;
    reg  [7:0] loop2_clock_divider;
    reg  [3:0] loop1_phase_enable;
    reg  [3:0] loop2_phase_enable;
    reg  [7:0] loop1_offtime_delay;
    reg  [7:0] loop2_offtime_delay;
    reg  [3:0] phase_loop_association;
    reg  [7:0] driver_routing_select;
    reg  [7:0] next_rdata;
    reg  [3:0] next_gate;
    wire [3:0] loop1_phase;
    wire [3:0] loop2_phase;
    wire       wr_ok;
    wire [7:0] loop1_divisor;
    wire [7:0] loop2_divisor;
    wire [4:0] loop1_step_delay;
    wire [4:0] loop2_step_delay;
    wire [2:0] loop1_off_time;
    wire [2:0] loop2_off_time;
    wire       phase1_loop_assoc;
    wire       phase2_loop_assoc;
    wire       phase3_loop_assoc;
    wire       phase4_loop_assoc;
    wire [1:0] driver1_route_sel;
    wire [1:0] driver2_route_sel;
    wire [1:0] driver3_route_sel;
    wire [1:0] driver4_route_sel;
    wire       driver1_on;
    wire       driver2_on;
    wire       driver3_on;
    wire       driver4_on;

    // settings are locked while operating so running loops never see changes
    assign wr_ok = reg_wr_en && !config_finished; // RL15

    // loop timing fields; both loops share one coding so one layout serves both
    assign loop1_divisor    = loop1_clock_divider; // RL6
    assign loop2_divisor    = loop2_clock_divider; // RL6
    assign loop1_step_delay = loop1_offtime_delay[`MTR_STEP_DELAY_MSB:`MTR_STEP_DELAY_LSB]; // RL9
    assign loop2_step_delay = loop2_offtime_delay[`MTR_STEP_DELAY_MSB:`MTR_STEP_DELAY_LSB]; // RL11
    assign loop1_off_time   = loop1_offtime_delay[`MTR_OFF_TIME_MSB:`MTR_OFF_TIME_LSB]; // RL10
    assign loop2_off_time   = loop2_offtime_delay[`MTR_OFF_TIME_MSB:`MTR_OFF_TIME_LSB]; // RL11

    // per physical phase: owning loop, 0 selects loop 1
    assign phase1_loop_assoc = phase_loop_association[0]; // RL1
    assign phase2_loop_assoc = phase_loop_association[1]; // RL1
    assign phase3_loop_assoc = phase_loop_association[2]; // RL1
    assign phase4_loop_assoc = phase_loop_association[3]; // RL1

    // per driver: two-bit internal phase select, driver 1 in the low bits
    assign driver1_route_sel = driver_routing_select[1:0]; // RL3
    assign driver2_route_sel = driver_routing_select[3:2]; // RL3
    assign driver3_route_sel = driver_routing_select[5:4]; // RL3
    assign driver4_route_sel = driver_routing_select[7:6]; // RL3

    // per driver: enable bit; a cleared bit keeps that gate quiet
    assign driver1_on = gate_drive_enable[0]; // RL4
    assign driver2_on = gate_drive_enable[1]; // RL4
    assign driver3_on = gate_drive_enable[2]; // RL4
    assign driver4_on = gate_drive_enable[3]; // RL4

    // register writes; reserved upper nibbles are not stored
    always @(posedge clk) begin
        if (srst) begin
            gate_drive_enable      <= `MTR_RST_NIBBLE;
            loop1_clock_divider    <= `MTR_RST_BYTE;
            loop2_clock_divider    <= `MTR_RST_BYTE;
            loop1_phase_enable     <= `MTR_RST_NIBBLE;
            loop2_phase_enable     <= `MTR_RST_NIBBLE;
            loop1_offtime_delay    <= `MTR_RST_BYTE;
            loop2_offtime_delay    <= `MTR_RST_BYTE;
            phase_loop_association <= `MTR_RST_NIBBLE;
            driver_routing_select  <= `MTR_RST_BYTE;
        end else if (wr_ok) begin
            case (reg_addr)
                `MTR_GATE_DRIVE_ENABLE:      gate_drive_enable      <= reg_wdata[3:0];
                `MTR_LOOP1_CLOCK_DIVIDER:    loop1_clock_divider    <= reg_wdata;
                `MTR_LOOP2_CLOCK_DIVIDER:    loop2_clock_divider    <= reg_wdata;
                `MTR_LOOP1_PHASE_ENABLE:     loop1_phase_enable     <= reg_wdata[3:0];
                `MTR_LOOP2_PHASE_ENABLE:     loop2_phase_enable     <= reg_wdata[3:0];
                `MTR_LOOP1_OFFTIME_DELAY:    loop1_offtime_delay    <= reg_wdata;
                `MTR_LOOP2_OFFTIME_DELAY:    loop2_offtime_delay    <= reg_wdata; // RL11
                `MTR_PHASE_LOOP_ASSOCIATION: phase_loop_association <= reg_wdata[3:0];
                `MTR_DRIVER_ROUTING_SELECT:  driver_routing_select  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read mux; unmapped offsets and reserved bits read zero
    always @* begin
        case (reg_addr)
            `MTR_GATE_DRIVE_ENABLE:      next_rdata = {4'h0, gate_drive_enable};
            `MTR_LOOP1_CLOCK_DIVIDER:    next_rdata = loop1_clock_divider;
            `MTR_LOOP2_CLOCK_DIVIDER:    next_rdata = loop2_clock_divider;
            `MTR_LOOP1_PHASE_ENABLE:     next_rdata = {4'h0, loop1_phase_enable};
            `MTR_LOOP2_PHASE_ENABLE:     next_rdata = {4'h0, loop2_phase_enable};
            `MTR_LOOP1_OFFTIME_DELAY:    next_rdata = loop1_offtime_delay;
            `MTR_LOOP2_OFFTIME_DELAY:    next_rdata = loop2_offtime_delay;
            `MTR_PHASE_LOOP_ASSOCIATION: next_rdata = {4'h0, phase_loop_association};
            `MTR_DRIVER_ROUTING_SELECT:  next_rdata = driver_routing_select;
            `MTR_DRIVE_STATUS:           next_rdata = {4'h0, gate_drive};
            default:                     next_rdata = 8'h00;
        endcase
    end

    // read data is captured on the strobe and held until the next read
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rdata <= next_rdata;
        end
    end

    // both loops share clk as their only time base, so the spacing between
    // loops cannot drift; each loop divides it down to its own tick and is
    // held cleared while configuration is open
    mtr_loop #(
        .DIV_W (8),
        .NPH   (4)
    ) u_loop1 (
        .clk        (clk),
        .srst       (srst),
        .run        (config_finished),
        .divisor    (loop1_divisor),
        .step_delay (loop1_step_delay),
        .off_time   (loop1_off_time),
        .phase_en   (loop1_phase_enable),
        .phase_out  (loop1_phase)
    ); // RL5 RL16

    mtr_loop #(
        .DIV_W (8),
        .NPH   (4)
    ) u_loop2 (
        .clk        (clk),
        .srst       (srst),
        .run        (config_finished),
        .divisor    (loop2_divisor),
        .step_delay (loop2_step_delay),
        .off_time   (loop2_off_time),
        .phase_en   (loop2_phase_enable),
        .phase_out  (loop2_phase)
    ); // RL11 RL16

    // per driver: pick the loop, then the internal phase, then gate it;
    // a driver routed to a disabled internal phase follows that idle phase
    always @* begin
        next_gate = 4'h0;
        if (phase1_loop_assoc) begin // RL1
            next_gate[0] = loop2_phase[driver1_route_sel]; // RL3
        end else begin
            next_gate[0] = loop1_phase[driver1_route_sel]; // RL3
        end
        if (phase2_loop_assoc) begin // RL1
            next_gate[1] = loop2_phase[driver2_route_sel]; // RL3
        end else begin
            next_gate[1] = loop1_phase[driver2_route_sel]; // RL3
        end
        if (phase3_loop_assoc) begin // RL1
            next_gate[2] = loop2_phase[driver3_route_sel]; // RL3
        end else begin
            next_gate[2] = loop1_phase[driver3_route_sel]; // RL3
        end
        if (phase4_loop_assoc) begin // RL1
            next_gate[3] = loop2_phase[driver4_route_sel]; // RL3
        end else begin
            next_gate[3] = loop1_phase[driver4_route_sel]; // RL3
        end
        // enable and operation mode are applied last, so nothing leaks while idle
        next_gate = next_gate & {driver4_on, driver3_on, driver2_on, driver1_on}; // RL4
        next_gate = next_gate & {4{config_finished}}; // RL18
    end

    // registered so routing glitches never reach a gate driver
    always @(posedge clk) begin
        if (srst) begin
            gate_drive <= 4'h0;
        end else begin
            gate_drive <= next_gate;
        end
    end
endmodule

// ### dv/mtr_checker.sv
// port checker for the timing router top
// assumes one clock domain and bind onto mtr_top
`timescale 1ns/1ps
module mtr_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // mode and register port
    input wire logic       config_finished,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_rdata,
    // gate drivers
    input wire logic [3:0] gate_drive
);
    logic [3:0] en_sh;
    logic [7:0] div_sh;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // shadows follow only the writes that the lock lets through
    always @(posedge clk) begin
        if (srst) begin
            en_sh  <= 4'h0;
            div_sh <= 8'h00;
        end else if (reg_wr_en && !config_finished) begin
            if (reg_addr == 8'h01) en_sh <= reg_wdata[3:0];
            if (reg_addr == 8'h09) div_sh <= reg_wdata;
        end
    end
    reset_clear_a: assert property ($fell(srst) |-> reg_rdata == 8'h00 && gate_drive == 4'h0)
        else $error("outputs not clear after reset");
    idle_low_a: assert property (!config_finished |=> gate_drive == 4'h0)
        else $error("gate active outside operation");
    gate_mask_a: assert property ((gate_drive & ~en_sh) == 4'h0)
        else $error("disabled driver switching");
    rsvd_zero_a: assert property (reg_rd_en && reg_addr == 8'h0f |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    unmapped_zero_a: assert property (reg_rd_en && reg_addr > 8'h1f |=> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
    rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    div_lock_a: assert property (reg_rd_en && reg_addr == 8'h09 |=> reg_rdata == $past(div_sh))
        else $error("divider readback wrong");
    status_echo_a: assert property (reg_rd_en && reg_addr == 8'h1f |=>
        reg_rdata == {4'h0, $past(gate_drive)})
        else $error("status differs from gates");
endmodule

bind mtr_top mtr_checker mtr_checker_i (.clk, .srst, .config_finished, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_en, .reg_rdata, .gate_drive);

// ### dv/mtr_gate_model.sv
// four gate driver loads: count high cycles and turn-on edges
// assumes gate levels are sampled on the rising clock edge
`timescale 1ns/1ps
module mtr_gate_model (
    // clock and control
    input  wire logic            clk,
    input  wire logic            clear,
    // gate inputs
    input  wire logic [3:0]      gate_drive,
    // measurements
    output logic      [3:0][7:0] hi_cnt,
    output logic      [3:0][7:0] rise_cnt
);
    logic [3:0] last;
    // counting over whole periods makes the result independent of phase
    always @(posedge clk) begin
        last <= gate_drive;
        for (int d = 0; d < 4; d++) begin
            if (clear) begin
                hi_cnt[d]   <= 8'h00;
                rise_cnt[d] <= 8'h00;
            end else begin
                hi_cnt[d]   <= hi_cnt[d] + {7'h00, gate_drive[d]};
                rise_cnt[d] <= rise_cnt[d] + {7'h00, gate_drive[d] & ~last[d]};
            end
        end
    end
endmodule

// ### dv/multiphase_timing_router_tb.sv
// testbench for the timing router: register port and gate timing
// assumes inputs change on the falling clock edge
`timescale 1ns/1ps
module multiphase_timing_router_tb;
    logic clk = 1'b0, srst = 1'b1, config_finished = 1'b0, clear = 1'b1;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [3:0] gate_drive;
    logic [3:0][7:0] hi, rise;
    int err_count = 0;
    int check_count = 0;
    logic [7:0] regs [9] = '{8'h01, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
    always #4 clk = ~clk;
    mtr_top mtr_top_i (.clk(clk), .srst(srst), .config_finished(config_finished),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .gate_drive(gate_drive));
    mtr_gate_model mtr_gate_model_i (.clk(clk), .clear(clear), .gate_drive(gate_drive),
        .hi_cnt(hi), .rise_cnt(rise));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one idle cycle between strobes so no strobe is set twice at one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        chk(reg_rdata, exp);
    endtask
    // settle, then count over n cycles
    task automatic measure(input int n);
        repeat (16) @(negedge clk);
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        repeat (n) @(negedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        srst = 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h0f, 8'h0f);
        rd(8'h0f, 8'h0f);
        wr(8'h0d, 8'ha5);
        rd(8'h0d, 8'ha5);
        // two phases of loop 1 at full rate, shortest off time
        wr(8'h0d, 8'h00);
        wr(8'h0b, 8'h03);
        wr(8'h0f, 8'h00);
        wr(8'h10, 8'h04);
        wr(8'h01, 8'h03);
        config_finished = 1'b1;
        measure(40);
        chk(hi[0], 8'h14);
        chk(hi[1], 8'h14);
        chk(rise[0], 8'h14);
        chk(rise[1], 8'h14);
        chk(hi[2], 8'h00);
        chk({7'h00, gate_drive[0] ^ gate_drive[1]}, 8'h01);
        wr(8'h09, 8'h77);
        rd(8'h09, 8'h00);
        config_finished = 1'b0;
        rd(8'h1f, 8'h00);
        // loop 2 halved, delay 2, off 3; drivers 3 and 4 routed to idle phases
        wr(8'h0a, 8'h01);
        wr(8'h0e, 8'h0b);
        wr(8'h0c, 8'h03);
        wr(8'h0f, 8'h0f);
        wr(8'h10, 8'he4);
        wr(8'h01, 8'h0f);
        config_finished = 1'b1;
        measure(80);
        chk(hi[0], 8'h14);
        chk(hi[1], 8'h14);
        chk(rise[0], 8'h0a);
        chk(rise[1], 8'h0a);
        chk(hi[2], 8'h00);
        chk(hi[3], 8'h00);
        finish_test();
    end
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
endmodule
